// >>> rtm_cfg.svh
// Purpose: Named constants for the receive time slot mapper
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef RTM_CFG_SVH
`define RTM_CFG_SVH
`define RTM_MAP_DEPTH 8192
`define RTM_PTR_DEPTH 512
`define RTM_NUM_PORTS 32
`define RTM_DS0_BIT 17
`define RTM_CHAN_HI 13
`define RTM_CHAN_LO 3
`define RTM_GRP_HI 11
`define RTM_EN_BIT 2
`define RTM_MASK_BIT 1
`define RTM_FIRST_BIT 0
`define RTM_SEL_SLOT 2'h0
`define RTM_SEL_GMAP 2'h1
`define RTM_SEL_PPTR 2'h2
`define RTM_SEL_GPTR 2'h3
`define RTM_ADDR_ONE 13'h0001
`define RTM_ADDR_ZERO 13'h0000
`endif

// >>> rtm_pkg.sv
// Purpose: Types for the receive time slot mapper
// Assumes: Constants live in rtm_cfg.svh
// Notes: Nothing here is imported; use rtm_pkg::name
package rtm_pkg;
   typedef enum logic [1:0] {
      RTM_IDLE = 2'b00,
      RTM_SLOT = 2'b01,
      RTM_GPTR = 2'b10,
      RTM_GMAP = 2'b11
   } rtm_state_type;

   typedef struct packed {
      logic wr;
      logic [1:0] sel;
      logic [12:0] addr;
      logic [38:0] data;
   } rtm_cfg_wr_type;

   typedef struct packed {
      logic [4:0] port;
      logic [10:0] channel;
      logic slot_enable;
      logic mask_enable;
      logic first_slot;
      logic from_group;
   } rtm_result_type;

   typedef struct packed {
      logic [12:0] start;
      logic [12:0] length;
      logic [12:0] current;
   } rtm_gptr_type;
endpackage

// >>> rtm_port_src.sv
// Purpose: Serial port side that asks for slot lookups
// Assumes: Requests launched on the falling edge
// Notes: Gap argument models a slow port
`timescale 1ns/1ps
module rtm_port_src (
   input wire logic clk,
   input wire logic ready,
   output logic slot_req,
   output logic [4:0] slot_port
);
   initial slot_req = 1'b0;
   initial slot_port = 5'h00;
   task automatic send(input logic [4:0] p, input int gap);
      repeat (gap + 1) @(negedge clk);
      while (ready !== 1'b1) @(negedge clk);
      slot_req = 1'b1;
      slot_port = p;
      @(posedge clk);
      @(negedge clk);
      slot_req = 1'b0;
      // Stale port inverted so nothing leans on it
      slot_port = ~p;
   endtask
endmodule

// >>> rtm_rx_mapper.sv
// Purpose: Receive time slot to logical channel mapper
// Assumes: Requests and configuration come from logic on SYS_CLK
// Notes: One slot resolved at a time; READY low while busy
`timescale 1ns/1ps
`include "rtm_cfg.svh"

//Contract
// (RL1) Slot entries sit in two shared memories of 8192 entries, one slot map and one group map.
// (RL2) Two pointer memories of 512 entries hold per-port bounds and per-group pointers.
// (RL3) This block holds only the receive set of maps, configured on its own.
// (RL4) Each port resolves its slots only from entries between its start and end address.
// (RL5) A slot entry is a direct channel mapping or a group pointer that starts extraction.
// (RL6) A group slot reads start, length and current pointer, then the addressed group map entry.
// (RL7) Software sets the group bit only on ports in slot bus mode, else behaviour is undefined.
// (RL8) Several slots of one port may map to the same channel and merge into it.
// (RL9) Software never maps one channel to slots on more than one port.
// (RL10) In slot bus extraction mode several slots of a port may point to one group.
// (RL11) Software gives each port one slot map region and group maps where extraction is used.
// (RL12) Bit 17 of a slot entry selects direct mapping when 0 and group reference when 1.
// (RL13) Bits 13:3 carry the channel in direct mode, their lower 9 bits the group in group mode.
// (RL14) In direct mode bit 2 enables the slot, bit 1 the mask, bit 0 marks first slot.
// (RL15) A group map entry holds channel in 13:3, enable in 2, mask in 1, first slot in 0.
// (RL16) After the slot at a port's end address the next slot is at its start address.
// (RL17) Each group access advances the current pointer and wraps to start after length entries; any group pointer config write in that cycle drops it.
module rtm_rx_mapper (
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   input wire logic CE,
   input wire rtm_pkg::rtm_cfg_wr_type CFG,
   input wire logic [`RTM_NUM_PORTS-1:0] SLOT_BUS_PORT_MODE,
   input wire logic SLOT_REQ,
   input wire logic [4:0] SLOT_PORT,
   output logic READY,
   output logic RES_VALID,
   output rtm_pkg::rtm_result_type RES
);

   // Memories carry no reset; software loads them before enabling ports
   // Receive maps only; the transmit set is configured apart
   logic [17:0] slot_mem [0:`RTM_MAP_DEPTH-1]; // RL1 RL3
   logic [13:0] gmap_mem [0:`RTM_MAP_DEPTH-1]; // RL1
   logic [25:0] pptr_mem [0:`RTM_PTR_DEPTH-1]; // RL2
   rtm_pkg::rtm_gptr_type gptr_mem [0:`RTM_PTR_DEPTH-1]; // RL2

   rtm_pkg::rtm_state_type state_reg;
   rtm_pkg::rtm_state_type state_next;
   logic [4:0] port_reg;
   logic [17:0] slot_q_reg;
   logic [13:0] gmap_q_reg;
   rtm_pkg::rtm_gptr_type gptr_q_reg;
   logic [8:0] group_reg;
   logic [12:0] cur_ptr [0:`RTM_NUM_PORTS-1];
   logic take_req;
   logic slot_is_group;
   logic [12:0] gptr_adv;
   logic [12:0] gptr_last;

   // Taken only when idle; a request while busy is dropped without a sign
   assign take_req = CE && SLOT_REQ && (state_reg == rtm_pkg::RTM_IDLE);
   // Group bit honoured only on slot bus ports; elsewhere decoded as direct
   assign slot_is_group = slot_q_reg[`RTM_DS0_BIT] && SLOT_BUS_PORT_MODE[port_reg]; // RL12

   // Per-port running slot pointer
   // Bounds read from the pointer memory, so only one copy of them exists
   genvar gp;
   generate
      for (gp = 0; gp < `RTM_NUM_PORTS; gp = gp + 1) begin : g_port
         logic [25:0] bounds;
         logic [12:0] cur_reg;
         assign bounds = pptr_mem[gp];
         assign cur_ptr[gp] = cur_reg;
         always_ff @(posedge SYS_CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               cur_reg <= `RTM_ADDR_ZERO;
            end else if (CE) begin
               if (CFG.wr && CFG.sel == `RTM_SEL_PPTR && CFG.addr == 13'(gp)) begin
                  cur_reg <= CFG.data[25:13]; // RL4
               end else if (take_req && SLOT_PORT == 5'(gp)) begin
                  if (cur_reg == bounds[12:0]) begin
                     cur_reg <= bounds[25:13]; // RL16
                  end else begin
                     cur_reg <= 13'(cur_reg + `RTM_ADDR_ONE); // RL4
                  end
               end
            end
         end
      end
   endgenerate

   // Slot map and port pointer memories; one lookup per request
   always_ff @(posedge SYS_CLK) begin
      if (CE) begin
         if (CFG.wr && CFG.sel == `RTM_SEL_SLOT) begin
            slot_mem[CFG.addr] <= CFG.data[17:0];
         end
         if (CFG.wr && CFG.sel == `RTM_SEL_PPTR) begin
            pptr_mem[CFG.addr[8:0]] <= CFG.data[25:0];
         end
         if (take_req) begin
            slot_q_reg <= slot_mem[cur_ptr[SLOT_PORT]]; // RL4
         end
      end
   end

   // Group map memory read in the group-pointer step
   always_ff @(posedge SYS_CLK) begin
      if (CE) begin
         if (CFG.wr && CFG.sel == `RTM_SEL_GMAP) begin
            gmap_mem[CFG.addr] <= CFG.data[13:0];
         end
         if (state_reg == rtm_pkg::RTM_GPTR) begin
            gmap_q_reg <= gmap_mem[gptr_q_reg.current]; // RL6
         end
      end
   end

   // Length counts entries; wrap once current would reach start plus length
   assign gptr_adv = 13'(gptr_q_reg.current + `RTM_ADDR_ONE);
   assign gptr_last = 13'(gptr_q_reg.start + gptr_q_reg.length);

   // Group pointer memory; a config write to any group wins and drops the advance in that cycle
   always_ff @(posedge SYS_CLK) begin
      if (CE) begin
         if (CFG.wr && CFG.sel == `RTM_SEL_GPTR) begin
            gptr_mem[CFG.addr[8:0]] <= CFG.data;
         end else if (state_reg == rtm_pkg::RTM_GPTR) begin
            if (gptr_adv == gptr_last) begin
               gptr_mem[group_reg] <= '{gptr_q_reg.start, gptr_q_reg.length, gptr_q_reg.start}; // RL17
            end else begin
               gptr_mem[group_reg] <= '{gptr_q_reg.start, gptr_q_reg.length, gptr_adv}; // RL17
            end
         end
         if (state_reg == rtm_pkg::RTM_SLOT) begin
            gptr_q_reg <= gptr_mem[slot_q_reg[`RTM_GRP_HI:`RTM_CHAN_LO]]; // RL6 RL10
         end
      end
   end

   // Port and group kept for the later steps
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         group_reg <= 9'h000;
         port_reg <= 5'h00;
      end else if (CE) begin
         if (take_req) begin
            port_reg <= SLOT_PORT;
         end
         if (state_reg == rtm_pkg::RTM_SLOT) begin
            group_reg <= slot_q_reg[`RTM_GRP_HI:`RTM_CHAN_LO]; // RL13
         end
      end
   end

   // Group slots take two more steps than direct ones
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         rtm_pkg::RTM_IDLE: begin
            if (take_req) begin
               state_next = rtm_pkg::RTM_SLOT;
            end
         end
         rtm_pkg::RTM_SLOT: begin
            if (slot_is_group) begin
               state_next = rtm_pkg::RTM_GPTR; // RL5
            end else begin
               state_next = rtm_pkg::RTM_IDLE;
            end
         end
         rtm_pkg::RTM_GPTR: begin
            state_next = rtm_pkg::RTM_GMAP;
         end
         rtm_pkg::RTM_GMAP: begin
            state_next = rtm_pkg::RTM_IDLE;
         end
         default: begin
            state_next = rtm_pkg::RTM_IDLE;
         end
      endcase
   end

   // READY from a flop, not decoded from the state
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_reg <= rtm_pkg::RTM_IDLE;
         READY <= 1'b1;
      end else if (CE) begin
         state_reg <= state_next;
         READY <= (state_next == rtm_pkg::RTM_IDLE);
      end
   end

   // Result; the same channel may come from many slots of a port
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         RES_VALID <= 1'b0;
         RES <= '0;
      end else if (CE) begin
         RES_VALID <= 1'b0;
         if (state_reg == rtm_pkg::RTM_SLOT && !slot_is_group) begin
            RES_VALID <= 1'b1;
            RES.port <= port_reg;
            RES.channel <= slot_q_reg[`RTM_CHAN_HI:`RTM_CHAN_LO]; // RL13 RL8
            RES.slot_enable <= slot_q_reg[`RTM_EN_BIT]; // RL14
            RES.mask_enable <= slot_q_reg[`RTM_MASK_BIT]; // RL14
            RES.first_slot <= slot_q_reg[`RTM_FIRST_BIT]; // RL14
            RES.from_group <= 1'b0;
         end else if (state_reg == rtm_pkg::RTM_GMAP) begin
            RES_VALID <= 1'b1;
            RES.port <= port_reg;
            RES.channel <= gmap_q_reg[`RTM_CHAN_HI:`RTM_CHAN_LO]; // RL15
            RES.slot_enable <= gmap_q_reg[`RTM_EN_BIT]; // RL15
            RES.mask_enable <= gmap_q_reg[`RTM_MASK_BIT]; // RL15
            RES.first_slot <= gmap_q_reg[`RTM_FIRST_BIT]; // RL15
            RES.from_group <= 1'b1;
         end
      end
   end

endmodule

// >>> rtm_rx_mapper_props.sv
// Purpose: Port timing checks for the receive mapper
// Assumes: Sees only top module ports
// Notes: Latencies as handed over, 2 direct and 4 group
`timescale 1ns/1ps
`include "rtm_cfg.svh"
module rtm_rx_mapper_props (
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   input wire logic CE,
   input wire rtm_pkg::rtm_cfg_wr_type CFG,
   input wire logic [`RTM_NUM_PORTS-1:0] SLOT_BUS_PORT_MODE,
   input wire logic SLOT_REQ,
   input wire logic [4:0] SLOT_PORT,
   input wire logic READY,
   input wire logic RES_VALID,
   input wire rtm_pkg::rtm_result_type RES
);
   logic [4:0] port_reg;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   sequence take_s;
      CE && SLOT_REQ && READY;
   endsequence
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         port_reg <= 5'h00;
      end else if (CE && SLOT_REQ && READY) begin
         port_reg <= SLOT_PORT;
      end
   end
   busy_after_take_a: assert property (take_s |=> !READY) else $error("ready kept high");
   answer_bound_a: assert property (take_s |-> ##[2:4] RES_VALID) else $error("no result");
   valid_pulse_a: assert property (RES_VALID |=> !RES_VALID) else $error("valid too long");
   ready_result_a: assert property ($rose(READY) |-> RES_VALID) else $error("ready without result");
   result_hold_a: assert property (!RES_VALID |-> $stable(RES)) else $error("result moved");
   result_port_a: assert property (RES_VALID |-> RES.port == port_reg) else $error("wrong port");
   direct_latency_a: assert property (RES_VALID && !RES.from_group |-> $past(READY, 2))
      else $error("direct latency");
   group_latency_a: assert property (RES_VALID && RES.from_group |-> !$past(READY, 2) && !$past(READY, 3))
      else $error("group latency");
   group_mode_a: assert property (RES_VALID && RES.from_group |-> SLOT_BUS_PORT_MODE[RES.port])
      else $error("group on plain port");
endmodule

// >>> rtm_rx_mapper_tb.sv
// Purpose: Self-checking bench for the receive mapper
// Assumes: Port 0 in slot bus mode, ports 0 and 2 mapped
// Notes: Expected results built from entry layouts
`timescale 1ns/1ps
module rtm_rx_mapper_tb;
   logic sys_clk, arst_n, ce, slot_req, ready, res_valid;
   logic [4:0] slot_port;
   logic [31:0] slot_bus_port_mode;
   rtm_pkg::rtm_cfg_wr_type cfg;
   rtm_pkg::rtm_result_type res;
   int error_cnt = 0;
   int total_checks = 0;
   int cycle_cnt = 0;
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   rtm_rx_mapper dut_u (.SYS_CLK(sys_clk), .ARST_N(arst_n), .CE(ce), .CFG(cfg),
      .SLOT_BUS_PORT_MODE(slot_bus_port_mode), .SLOT_REQ(slot_req), .SLOT_PORT(slot_port),
      .READY(ready), .RES_VALID(res_valid), .RES(res));
   rtm_port_src src_u (.clk(sys_clk), .ready(ready), .slot_req(slot_req), .slot_port(slot_port));
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] sel, input logic [12:0] a, input logic [38:0] d);
      cfg = '{1'b1, sel, a, d};
      @(negedge sys_clk);
   endtask
   function automatic rtm_pkg::rtm_result_type ex(input logic [4:0] p, input logic [10:0] c,
      input logic [2:0] f, input logic g);
      return {p, c, f, g};
   endfunction
   task automatic run(input logic [4:0] p, input int gap, input rtm_pkg::rtm_result_type e);
      src_u.send(p, gap);
      for (int i = 0; i < 8 && res_valid !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      chk("valid", 20'(res_valid), 20'h00001);
      chk("result", res, e);
   endtask
   always @(posedge sys_clk) begin
      cycle_cnt++;
      if (cycle_cnt == 2000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      ce = 1'b1;
      cfg = '0;
      slot_bus_port_mode = 32'h0000_0001;
      arst_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      arst_n = 1'b1;
      chk("ready", 20'(ready), 20'h00001);
      chk("reset valid", 20'(res_valid), 20'h00000);
      chk("reset result", res, 20'h00000);
      wr(2'h2, 13'h0000, {13'h0000, 13'h0010, 13'h0013});
      wr(2'h2, 13'h0002, {13'h0000, 13'h0040, 13'h0040});
      wr(2'h0, 13'h0010, 39'h000000002d);
      wr(2'h0, 13'h0011, 39'h0000020018);
      wr(2'h0, 13'h0012, 39'h000000002c);
      wr(2'h0, 13'h0013, 39'h0000020018);
      wr(2'h0, 13'h0040, 39'h000000003f);
      wr(2'h3, 13'h0003, {13'h0020, 13'h0002, 13'h0020});
      wr(2'h1, 13'h0020, 39'h000000004c);
      wr(2'h1, 13'h0021, 39'h0000000056);
      cfg.wr = 1'b0;
      run(5'h00, 0, ex(5'h00, 11'h005, 3'h5, 1'b0));
      run(5'h00, 0, ex(5'h00, 11'h009, 3'h4, 1'b1));
      run(5'h02, 3, ex(5'h02, 11'h007, 3'h7, 1'b0));
      run(5'h00, 0, ex(5'h00, 11'h005, 3'h4, 1'b0));
      run(5'h00, 0, ex(5'h00, 11'h00a, 3'h6, 1'b1));
      run(5'h00, 0, ex(5'h00, 11'h005, 3'h5, 1'b0));
      run(5'h00, 0, ex(5'h00, 11'h009, 3'h4, 1'b1));
      @(negedge sys_clk);
      @(negedge sys_clk);
      // Write while frozen must be dropped; port 2 still sees channel 7
      ce = 1'b0;
      wr(2'h0, 13'h0040, 39'h0000000000);
      cfg.wr = 1'b0;
      ce = 1'b1;
      run(5'h02, 0, ex(5'h02, 11'h007, 3'h7, 1'b0));
      end_sim();
   end
endmodule
bind rtm_rx_mapper rtm_rx_mapper_props props_u (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CE(CE), .CFG(CFG),
   .SLOT_BUS_PORT_MODE(SLOT_BUS_PORT_MODE), .SLOT_REQ(SLOT_REQ), .SLOT_PORT(SLOT_PORT), .READY(READY),
   .RES_VALID(RES_VALID), .RES(RES));
